// >>> prc_soft_reset_ctrl.sv
// Operation
// - First word writes gated by capability mask A
// - Second word writes gated by capability mask B
// - Both words reset zero, read/write at offsets
// - First word bit 20 resets PWM
// - First word bit 16 resets ADC0
// - First word bit 6 resets hibernation
// - First word bit 3 resets watchdog
// - Second word bits 25,24 reset comparators
// - Second word bits 19:16 reset counters
// - Second word bit 14 resets second I2C
// - Unassigned bits read-only, read zero
//
// Design decision made here: the APB interface to the registers.
module prc_soft_reset_ctrl
	import prc_pkg::*;
(
	input  wire logic                  mclk_in,
	input  wire logic                  rst_b_in,
	input  wire logic                  psel_in,
	input  wire logic                  penable_in,
	input  wire logic                  pwrite_in,
	input  wire logic [PRC_ADDR_W-1:0] paddr_in,
	input  wire logic [PRC_DATA_W-1:0] pwdata_in,
	input  wire logic [3:0]            pstrb_in,
	input  wire logic [PRC_DATA_W-1:0] capability_mask_a_in,
	input  wire logic [PRC_DATA_W-1:0] capability_mask_b_in,
	output logic      [PRC_DATA_W-1:0] prdata_out,
	output logic                       pready_out,
	output logic                       pslverr_out,
	output prc_unit_rst_s              unit_rst_out
);

	logic [PRC_DATA_W-1:0] word0_view;
	logic [PRC_DATA_W-1:0] word1_view;
	logic [PRC_DATA_W-1:0] merged0;
	logic [PRC_DATA_W-1:0] merged1;
	logic                  wr_en0;
	logic                  wr_en1;
	logic                  pwm_ctl_r;
	logic                  adc0_ctl_r;
	logic                  hibern_ctl_r;
	logic                  wdog_ctl_r;
	logic                  cmp_b_ctl_r;
	logic                  cmp_a_ctl_r;
	logic                  gpc_d_ctl_r;
	logic                  gpc_c_ctl_r;
	logic                  gpc_b_ctl_r;
	logic                  gpc_a_ctl_r;
	logic                  i2c1_ctl_r;
	logic                  pwm_line_r;
	logic                  adc0_line_r;
	logic                  hibern_line_r;
	logic                  wdog_line_r;
	logic                  cmp_b_line_r;
	logic                  cmp_a_line_r;
	logic                  gpc_d_line_r;
	logic                  gpc_c_line_r;
	logic                  gpc_b_line_r;
	logic                  gpc_a_line_r;
	logic                  i2c1_line_r;
	logic [PRC_DATA_W-1:0] allow0;
	logic [PRC_DATA_W-1:0] allow1;
	logic [PRC_DATA_W-1:0] rd_mux;
	logic                  pready_r;
	logic                  access;
	logic                  done;
	logic                  sel0;
	logic                  sel1;

	// Byte-lane merge of write data into the old word
	function automatic logic [31:0] lane_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  strb
	);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction : lane_merge

	// Capability gates both the write and the held value
	function automatic logic ctl_next(
		input logic old_v,
		input logic wr_v,
		input logic new_v,
		input logic allow_v
	);
		logic res;
		res = wr_v ? new_v : old_v;
		return res & allow_v;
	endfunction : ctl_next

	assign access = psel_in & penable_in;
	// Completion edge: the only edge where a write lands
	assign done   = access & pready_r;
	assign sel0   = (paddr_in == PRC_OFF_WORD0);
	assign sel1   = (paddr_in == PRC_OFF_WORD1);

	// Capability and existence combined; absent bits can never be 1
	assign allow0 = capability_mask_a_in & PRC_IMPL_WORD0;
	assign allow1 = capability_mask_b_in & PRC_IMPL_WORD1;

	// A write lands only at the completion edge, with its byte lanes
	assign wr_en0  = done & pwrite_in & sel0;
	assign wr_en1  = done & pwrite_in & sel1;
	assign merged0 = lane_merge(word0_view, pwdata_in, pstrb_in);
	assign merged1 = lane_merge(word1_view, pwdata_in, pstrb_in);

	always_comb begin
		rd_mux = '0;
		if (sel0) begin
			rd_mux = word0_view & allow0;
		end else if (sel1) begin
			rd_mux = word1_view & allow1;
		end
	end

	// Stored bits follow a dropping capability too, so a unit that
	// disappears is never left parked in reset
	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			pwm_ctl_r <= PRC_RST_WORD0[PRC_B0_PWM];
		end else begin
			pwm_ctl_r <= ctl_next(pwm_ctl_r, wr_en0, merged0[PRC_B0_PWM],
				allow0[PRC_B0_PWM]);
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			adc0_ctl_r <= PRC_RST_WORD0[PRC_B0_ADC0];
		end else begin
			adc0_ctl_r <= ctl_next(adc0_ctl_r, wr_en0, merged0[PRC_B0_ADC0],
				allow0[PRC_B0_ADC0]);
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			hibern_ctl_r <= PRC_RST_WORD0[PRC_B0_HIBERN];
		end else begin
			hibern_ctl_r <= ctl_next(hibern_ctl_r, wr_en0,
				merged0[PRC_B0_HIBERN], allow0[PRC_B0_HIBERN]);
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			wdog_ctl_r <= PRC_RST_WORD0[PRC_B0_WATCHDOG];
		end else begin
			wdog_ctl_r <= ctl_next(wdog_ctl_r, wr_en0,
				merged0[PRC_B0_WATCHDOG], allow0[PRC_B0_WATCHDOG]);
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			cmp_b_ctl_r <= PRC_RST_WORD1[PRC_B1_CMP_B];
		end else begin
			cmp_b_ctl_r <= ctl_next(cmp_b_ctl_r, wr_en1, merged1[PRC_B1_CMP_B],
				allow1[PRC_B1_CMP_B]);
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			cmp_a_ctl_r <= PRC_RST_WORD1[PRC_B1_CMP_A];
		end else begin
			cmp_a_ctl_r <= ctl_next(cmp_a_ctl_r, wr_en1, merged1[PRC_B1_CMP_A],
				allow1[PRC_B1_CMP_A]);
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			gpc_d_ctl_r <= PRC_RST_WORD1[PRC_B1_GPC_D];
		end else begin
			gpc_d_ctl_r <= ctl_next(gpc_d_ctl_r, wr_en1, merged1[PRC_B1_GPC_D],
				allow1[PRC_B1_GPC_D]);
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			gpc_c_ctl_r <= PRC_RST_WORD1[PRC_B1_GPC_C];
		end else begin
			gpc_c_ctl_r <= ctl_next(gpc_c_ctl_r, wr_en1, merged1[PRC_B1_GPC_C],
				allow1[PRC_B1_GPC_C]);
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			gpc_b_ctl_r <= PRC_RST_WORD1[PRC_B1_GPC_B];
		end else begin
			gpc_b_ctl_r <= ctl_next(gpc_b_ctl_r, wr_en1, merged1[PRC_B1_GPC_B],
				allow1[PRC_B1_GPC_B]);
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			gpc_a_ctl_r <= PRC_RST_WORD1[PRC_B1_GPC_A];
		end else begin
			gpc_a_ctl_r <= ctl_next(gpc_a_ctl_r, wr_en1, merged1[PRC_B1_GPC_A],
				allow1[PRC_B1_GPC_A]);
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			i2c1_ctl_r <= PRC_RST_WORD1[PRC_B1_I2C1];
		end else begin
			i2c1_ctl_r <= ctl_next(i2c1_ctl_r, wr_en1, merged1[PRC_B1_I2C1],
				allow1[PRC_B1_I2C1]);
		end
	end

	// Unassigned positions stay zero in the assembled words
	always_comb begin
		word0_view                   = '0;
		word0_view[PRC_B0_PWM]       = pwm_ctl_r;
		word0_view[PRC_B0_ADC0]      = adc0_ctl_r;
		word0_view[PRC_B0_HIBERN]    = hibern_ctl_r;
		word0_view[PRC_B0_WATCHDOG]  = wdog_ctl_r;
	end

	always_comb begin
		word1_view                   = '0;
		word1_view[PRC_B1_CMP_B]     = cmp_b_ctl_r;
		word1_view[PRC_B1_CMP_A]     = cmp_a_ctl_r;
		word1_view[PRC_B1_GPC_D]     = gpc_d_ctl_r;
		word1_view[PRC_B1_GPC_C]     = gpc_c_ctl_r;
		word1_view[PRC_B1_GPC_B]     = gpc_b_ctl_r;
		word1_view[PRC_B1_GPC_A]     = gpc_a_ctl_r;
		word1_view[PRC_B1_I2C1]      = i2c1_ctl_r;
	end

	// One wait state: pready rises in the second access cycle
	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			pready_r    <= 1'b0;
			prdata_out  <= '0;
			pslverr_out <= 1'b0;
		end else if (access && !pready_r) begin
			pready_r    <= 1'b1;
			prdata_out  <= pwrite_in ? '0 : rd_mux;
			pslverr_out <= !(sel0 || sel1);
		end else begin
			pready_r    <= 1'b0;
			prdata_out  <= '0;
			pslverr_out <= 1'b0;
		end
	end

	assign pready_out = pready_r;

	// Reset lines are flopped copies; they lag the stored bit one cycle
	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			pwm_line_r <= 1'b0;
		end else begin
			pwm_line_r <= pwm_ctl_r;
		end
	end
	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			adc0_line_r <= 1'b0;
		end else begin
			adc0_line_r <= adc0_ctl_r;
		end
	end
	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			hibern_line_r <= 1'b0;
		end else begin
			hibern_line_r <= hibern_ctl_r;
		end
	end
	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			wdog_line_r <= 1'b0;
		end else begin
			wdog_line_r <= wdog_ctl_r;
		end
	end
	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			cmp_b_line_r <= 1'b0;
		end else begin
			cmp_b_line_r <= cmp_b_ctl_r;
		end
	end
	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			cmp_a_line_r <= 1'b0;
		end else begin
			cmp_a_line_r <= cmp_a_ctl_r;
		end
	end
	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			gpc_d_line_r <= 1'b0;
		end else begin
			gpc_d_line_r <= gpc_d_ctl_r;
		end
	end
	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			gpc_c_line_r <= 1'b0;
		end else begin
			gpc_c_line_r <= gpc_c_ctl_r;
		end
	end
	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			gpc_b_line_r <= 1'b0;
		end else begin
			gpc_b_line_r <= gpc_b_ctl_r;
		end
	end
	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			gpc_a_line_r <= 1'b0;
		end else begin
			gpc_a_line_r <= gpc_a_ctl_r;
		end
	end
	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			i2c1_line_r <= 1'b0;
		end else begin
			i2c1_line_r <= i2c1_ctl_r;
		end
	end

	// Struct order, most significant first
	assign unit_rst_out = {
		pwm_line_r,
		adc0_line_r,
		hibern_line_r,
		wdog_line_r,
		cmp_b_line_r,
		cmp_a_line_r,
		gpc_d_line_r,
		gpc_c_line_r,
		gpc_b_line_r,
		gpc_a_line_r,
		i2c1_line_r
	};

endmodule : prc_soft_reset_ctrl

// >>> prc_pkg.sv
package prc_pkg;

	localparam int          PRC_ADDR_W      = 12;
	localparam int          PRC_DATA_W      = 32;

	// Register offsets inside the system-control space
	localparam logic [11:0] PRC_OFF_WORD0   = 12'h040;
	localparam logic [11:0] PRC_OFF_WORD1   = 12'h044;

	localparam logic [31:0] PRC_RST_WORD0   = 32'h0000_0000;
	localparam logic [31:0] PRC_RST_WORD1   = 32'h0000_0000;

	// Field positions, first word
	localparam int          PRC_B0_PWM      = 20;
	localparam int          PRC_B0_ADC0     = 16;
	localparam int          PRC_B0_HIBERN   = 6;
	localparam int          PRC_B0_WATCHDOG = 3;

	// Field positions, second word
	localparam int          PRC_B1_CMP_B    = 25;
	localparam int          PRC_B1_CMP_A    = 24;
	localparam int          PRC_B1_GPC_D    = 19;
	localparam int          PRC_B1_GPC_C    = 18;
	localparam int          PRC_B1_GPC_B    = 17;
	localparam int          PRC_B1_GPC_A    = 16;
	localparam int          PRC_B1_I2C1     = 14;

	// Bits that exist at all; everything else is read-only zero
	localparam logic [31:0] PRC_IMPL_WORD0  = (32'h1 << PRC_B0_PWM)
		| (32'h1 << PRC_B0_ADC0)
		| (32'h1 << PRC_B0_HIBERN)
		| (32'h1 << PRC_B0_WATCHDOG);
	localparam logic [31:0] PRC_IMPL_WORD1  = (32'h1 << PRC_B1_CMP_B)
		| (32'h1 << PRC_B1_CMP_A)
		| (32'h1 << PRC_B1_GPC_D)
		| (32'h1 << PRC_B1_GPC_C)
		| (32'h1 << PRC_B1_GPC_B)
		| (32'h1 << PRC_B1_GPC_A)
		| (32'h1 << PRC_B1_I2C1);

	// Per-unit reset lines, high holds the unit in reset
	typedef struct packed {
		logic pwm;
		logic adc0;
		logic hibernation_reset_bit;
		logic watchdog_reset_bit;
		logic comparator_b_reset_bit;
		logic comparator_a_reset_bit;
		logic gp_counter_d_reset_bit;
		logic gp_counter_c_reset_bit;
		logic gp_counter_b_reset_bit;
		logic gp_counter_a_reset_bit;
		logic i2c1;
	} prc_unit_rst_s;

endpackage : prc_pkg

// >>> prc_units.sv
module prc_units
	import prc_pkg::*;
(
	input  wire logic          mclk_in,
	input  wire prc_unit_rst_s unit_rst_in,
	output logic [10:0]        held_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// A unit stays in its reset state for as long as its line is high
	always_ff @(posedge mclk_in) begin
		held_out <= unit_rst_in;
	end
endmodule : prc_units

// >>> prc_soft_reset_ctrl_sva.sv
module prc_chk
	import prc_pkg::*;
(
	input wire logic mclk_in, rst_b_in, psel_in, penable_in, pwrite_in,
	input wire logic pready_out, pslverr_out,
	input wire logic [11:0] paddr_in,
	input wire logic [3:0] pstrb_in,
	input wire logic [31:0] pwdata_in, prdata_out,
	input wire logic [31:0] capability_mask_a_in, capability_mask_b_in,
	input wire prc_unit_rst_s unit_rst_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);
	wire wr0 = pready_out && pwrite_in && paddr_in == PRC_OFF_WORD0
		&& pstrb_in == 4'hf;
	wire wr1 = pready_out && pwrite_in && paddr_in == PRC_OFF_WORD1
		&& pstrb_in == 4'hf;
	wire hit = paddr_in == PRC_OFF_WORD0 || paddr_in == PRC_OFF_WORD1;
	wire [31:0] ok = paddr_in[2] ? PRC_IMPL_WORD1 & capability_mask_b_in
		: PRC_IMPL_WORD0 & capability_mask_a_in;
	wire [3:0] gpc = pwdata_in[19:16] & capability_mask_b_in[19:16];
	a_ready_wait: assert property ($rose(psel_in && penable_in) |=>
		pready_out) else $error("no answer after access edge");
	a_ready_pulse: assert property (pready_out |=> !pready_out)
		else $error("ready held too long");
	a_err_map: assert property (pready_out |-> pslverr_out == !hit)
		else $error("error flag wrong for address");
	a_rd_masked: assert property (pready_out && !pwrite_in |->
		(prdata_out & ~ok) == 0) else $error("absent bit read as one");
	a_pwm_set: assert property (wr0 && pwdata_in[20] &&
		capability_mask_a_in[20] |-> ##2 unit_rst_out.pwm)
		else $error("pwm line not raised");
	a_wdog_clr: assert property (wr0 && !pwdata_in[3] |->
		##2 !unit_rst_out.watchdog_reset_bit) else $error("watchdog line held");
	// Counter lines sit at struct bits 4:1
	a_gpc_word: assert property (wr1 |-> ##2
		unit_rst_out[4:1] == $past(gpc, 2)) else $error("counter lines wrong");
	a_rst_steady: assert property ($changed(unit_rst_out) |->
		$past(wr0 || wr1, 2)) else $error("reset line moved without write");
endmodule : prc_chk
bind prc_soft_reset_ctrl prc_chk u_chk (.*);

// >>> tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import prc_pkg::*;
	logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, e, pready, perr;
	logic [11:0] addr = 0, ad;
	logic [3:0] strb = 4'hf;
	logic [31:0] wd = 0, cap_a = '1, cap_b = '1, q, d, w0, w1, prdata;
	logic [10:0] held;
	prc_unit_rst_s urst;
	int n_fail = 0, total_checks = 0, cyc = 0;
	always #2 clk = ~clk;
	prc_soft_reset_ctrl dut (.mclk_in(clk), .rst_b_in(rst_b), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(addr), .pwdata_in(wd),
		.pstrb_in(strb), .capability_mask_a_in(cap_a),
		.capability_mask_b_in(cap_b), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(perr), .unit_rst_out(urst));
	prc_units u_units (.mclk_in(clk), .unit_rst_in(urst), .held_out(held));
	task results;
		$display("checks %0d fails %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : results
	task chk(string s, logic [31:0] x, y);
		total_checks++;
		if (x !== y) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", s, x, y);
		end
	endtask : chk
	task xfer(logic w, logic [11:0] a, logic [31:0] v);
		@(posedge clk) {psel, pwr, addr, wd} <= {1'b1, w, a, v};
		@(posedge clk) pen <= 1;
		do @(posedge clk); while (pready !== 1);
		q = prdata;
		e = perr;
		{psel, pen} <= 2'b00;
	endtask : xfer
	function logic [31:0] unit_exp(logic [31:0] a, b);
		return {21'h0, a[20], a[16], a[6], a[3], b[25], b[24], b[19:16], b[14]};
	endfunction : unit_exp
	always @(posedge clk) if (++cyc > 5000) begin
		n_fail++;
		results;
	end
	initial begin
		void'($urandom(28675));
		for (int p = 0; p < 2; p++) begin
			// Masks move only in reset, so stored bits never clear under us
			rst_b <= 0;
			cap_a <= p ? $urandom : '1;
			cap_b <= p ? $urandom : '1;
			{w0, w1} = 0;
			repeat (2) @(posedge clk);
			rst_b <= 1;
			xfer(0, 12'h040, 0); chk("word0 reset", 0, q);
			xfer(0, 12'h044, 0); chk("word1 reset", 0, q);
			xfer(1, 12'h046, '1); chk("unmapped wr", 1, e);
			xfer(0, 12'h048, 0); chk("unmapped rd", 0, q);
			repeat (24) begin
				ad = $urandom_range(1) ? 12'h044 : 12'h040;
				d = $urandom_range(3) == 0 ? '1 : $urandom;
				xfer(1, ad, d);
				if (ad[2]) w1 = d & PRC_IMPL_WORD1 & cap_b;
				else w0 = d & PRC_IMPL_WORD0 & cap_a;
				xfer(0, ad, 0); chk("readback", ad[2] ? w1 : w0, q);
				chk("unit lines", unit_exp(w0, w1), {21'h0, held});
			end
			strb <= 4'h0;
			xfer(1, 12'h040, '1);
			strb <= 4'hf;
			xfer(0, 12'h040, 0); chk("no-lane write", w0, q);
			// Read-modify-write keeps reserved bits as read
			xfer(1, 12'h040, q ^ 32'h0000_0008);
			w0 = w0 ^ (32'h0000_0008 & cap_a);
			xfer(0, 12'h040, 0); chk("rmw readback", w0, q);
			chk("rmw lines", unit_exp(w0, w1), {21'h0, held});
			$display("phase %0d done", p);
		end
		results;
	end
endmodule : tb_top
